/* File: hdl/asrs_cfg.svh */
`ifndef ASRS_CFG_SVH
`define ASRS_CFG_SVH
`define ASRS_ADDR_W 4
`define ASRS_OFF_CTRL 4'h0
`define ASRS_OFF_WBP 4'h1
`define ASRS_OFF_LAST 4'h2
`define ASRS_OFF_SHLO 4'h3
`define ASRS_CTRL_RND_BIT 0
`define ASRS_CTRL_SAT_BIT 1
`define ASRS_CTRL_RST 2'h0
`define ASRS_WBP_RST 16'h0000
`define ASRS_WB_STEP 16'h0002
`define ASRS_POS_MAX 16'h7FFF
`define ASRS_NEG_MAX 16'h8000
`define ASRS_HALF 16'h8000
`define ASRS_SH_MAX 6'sd16
`endif

/* File: hdl/asrs_pkg.sv */
package asrs_pkg;
   typedef enum logic [2:0] {
      ASRS_OP_NONE = 3'h0,
      ASRS_OP_STORE_TRUNC = 3'h1,
      ASRS_OP_STORE_RND = 3'h2,
      ASRS_OP_MAC_WB = 3'h3,
      ASRS_OP_MULTIPLY_ONLY = 3'h4,
      ASRS_OP_NEGATED_MULTIPLY = 3'h5,
      ASRS_OP_DISTANCE_SQUARE = 3'h6,
      ASRS_OP_DISTANCE_SQUARE_ACC = 3'h7
   } asrs_op_t;
   typedef enum logic {
      ASRS_WB_DIRECT = 1'b0,
      ASRS_WB_INDIRECT = 1'b1
   } asrs_wb_mode_t;
   typedef enum logic [1:0] {
      ASRS_SRC_ACC_A = 2'h0,
      ASRS_SRC_ACC_B = 2'h1,
      ASRS_SRC_XBUS = 2'h2
   } asrs_src_t;
   typedef struct packed {
      asrs_op_t op;
      asrs_wb_mode_t wb_mode;
      logic target_b;
      logic [15:0] addr;
   } asrs_store_req_t;
   typedef struct packed {
      asrs_src_t src;
      logic signed [5:0] amount;
      logic arith;
   } asrs_shift_req_t;
endpackage

/* File: hdl/asrs_store.sv */
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "asrs_cfg.svh"
// Notes on behaviour
// RL1: Accumulate ops write back non-target high word.
// RL2: Write-back travels X bus, unified data space; direct mode loads only the pointer, no X bus write.
// RL3: Direct mode puts rounded value in pointer.
// RL4: Indirect mode stores at pointer, adds two.
// RL5: Combinational rounding, biased or convergent by mode.
// RL6: No rounding: truncate high word, drop low.
// RL7: Low word 0x8000 and up increments high.
// RL8: Exactly 0x8000 increments only if bit16 set.
// RL9: Store ops write target, truncated or rounded.
// RL10: Accumulate write-back always rounds.
// RL11: Write saturation never alters the accumulator.
// RL12: Above 0x007FFF writes 0x7FFF when saturating.
// RL13: Below 0xFF8000 writes 0x8000 when saturating.
// RL14: Sign from bit 39, plus overflow inputs.
// RL15: Saturation off passes value unchanged.
// RL16: Shift up to 16 either way, one cycle.
// RL17: Shifter source accumulator A, B or X bus.
// RL18: Signed amount: positive right, negative left.
// RL19: Shifter is 40 bits wide.
// RL20: X bus enters bits 16-31 right, 0-15 left.
// RL21: Accumulators are 40 bits with guard bits.
module asrs_store (
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic [`ASRS_ADDR_W-1:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [15:0] REG_RDATA,
   input wire logic [39:0] ACC_A,
   input wire logic [39:0] ACC_B,
   input wire logic ACC_A_OVF,
   input wire logic ACC_B_OVF,
   input wire logic STORE_REQ,
   input wire asrs_pkg::asrs_store_req_t STORE_CMD,
   input wire logic SHIFT_REQ,
   input wire asrs_pkg::asrs_shift_req_t SHIFT_CMD,
   input wire logic [15:0] XBUS_RDATA,
   output logic XW_EN,
   output logic [15:0] XW_ADDR,
   output logic [15:0] XW_DATA,
   output logic [15:0] WB_POINTER,
   output logic SH_VALID,
   output logic [39:0] SH_RESULT
);
   import asrs_pkg::*;

   // Round the high word of a 40-bit accumulator; the result keeps
   // the guard bits so that the saturation stage can see overflow.
   function automatic logic [23:0] round_hi(
      input logic [39:0] acc,
      input logic rnd_en,
      input logic convergent
   );
      logic inc;
      inc = 1'b0;
      if (rnd_en) begin
         inc = acc[15]; // RL7
         if (convergent && acc[15:0] == `ASRS_HALF) begin
            inc = acc[16]; // RL8
         end
      end
      round_hi = acc[39:16] + {23'h000000, inc}; // RL6
   endfunction

   // Clamp a rounded 24-bit value to 1.15 when saturation is on.
   function automatic logic [15:0] sat_word(
      input logic [23:0] v,
      input logic sign,
      input logic ovf,
      input logic sat_en
   );
      logic hi_pos;
      logic hi_neg;
      hi_pos = (v[23:15] != 9'h000);
      // A negative source that rounds up to zero is still in range.
      hi_neg = v[23] && (v[23:15] != 9'h1FF);
      sat_word = v[15:0]; // RL15
      if (sat_en) begin
         if (!sign && (hi_pos || ovf)) begin
            sat_word = `ASRS_POS_MAX; // RL12
         end else if (sign && (hi_neg || ovf)) begin
            sat_word = `ASRS_NEG_MAX; // RL13
         end
      end
   endfunction

   function automatic logic wb_op(input asrs_op_t op);
      wb_op = (op == ASRS_OP_MAC_WB);
   endfunction

   logic [1:0] ctrl_q;
   logic [15:0] wbp_q;
   logic [15:0] last_q;
   logic round_mode_select;
   logic data_write_saturate_enable;
   logic [39:0] src_acc;
   logic src_ovf;
   logic do_round;
   logic [23:0] rounded;
   logic [15:0] store_word;
   logic is_store;
   logic is_wb;
   logic [39:0] sh_operand;
   logic [4:0] sh_mag;
   logic signed [5:0] sh_amt;
   logic [39:0] sh_next;

   assign round_mode_select = ctrl_q[`ASRS_CTRL_RND_BIT];
   assign data_write_saturate_enable = ctrl_q[`ASRS_CTRL_SAT_BIT];

   assign is_store = STORE_REQ && (STORE_CMD.op == ASRS_OP_STORE_TRUNC ||
                     STORE_CMD.op == ASRS_OP_STORE_RND);
   // Plain, negated and distance multiplies never write back.
   assign is_wb = STORE_REQ && wb_op(STORE_CMD.op); // RL1

   // Write-back reads the accumulator the operation does not target.
   always_comb begin
      if (wb_op(STORE_CMD.op)) begin
         src_acc = STORE_CMD.target_b ? ACC_A : ACC_B; // RL1
         src_ovf = STORE_CMD.target_b ? ACC_A_OVF : ACC_B_OVF;
      end else begin
         src_acc = STORE_CMD.target_b ? ACC_B : ACC_A; // RL9
         src_ovf = STORE_CMD.target_b ? ACC_B_OVF : ACC_A_OVF;
      end
   end

   assign do_round = (STORE_CMD.op != ASRS_OP_STORE_TRUNC); // RL10
   assign rounded = round_hi(src_acc, do_round, round_mode_select); // RL5
   // Only the written word is clamped; accumulators are inputs here.
   assign store_word = sat_word(rounded, src_acc[39], src_ovf,
                                data_write_saturate_enable); // RL11 RL14

   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ctrl_q <= `ASRS_CTRL_RST;
      end else if (REG_WR && REG_ADDR == `ASRS_OFF_CTRL) begin
         ctrl_q <= REG_WDATA[1:0];
      end
   end

   // A software write to the pointer in the same cycle as a hardware
   // update loses, so that the write-back result is never dropped.
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         wbp_q <= `ASRS_WBP_RST;
      end else if (is_wb && STORE_CMD.wb_mode == ASRS_WB_DIRECT) begin
         wbp_q <= store_word; // RL3
      end else if (is_wb) begin
         wbp_q <= wbp_q + `ASRS_WB_STEP; // RL4
      end else if (REG_WR && REG_ADDR == `ASRS_OFF_WBP) begin
         wbp_q <= REG_WDATA;
      end
   end

   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         last_q <= 16'h0000;
      end else if (is_wb || is_store) begin
         last_q <= store_word;
      end
   end

   // Memory write over the X bus, registered one cycle after request.
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         XW_EN <= 1'b0;
         XW_ADDR <= 16'h0000;
         XW_DATA <= 16'h0000;
      end else begin
         XW_EN <= is_store ||
                  (is_wb && STORE_CMD.wb_mode == ASRS_WB_INDIRECT); // RL2
         if (is_store) begin
            XW_ADDR <= STORE_CMD.addr; // RL9
            XW_DATA <= store_word;
         end else if (is_wb && STORE_CMD.wb_mode == ASRS_WB_INDIRECT) begin
            XW_ADDR <= wbp_q; // RL4
            XW_DATA <= store_word;
         end
      end
   end

   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         WB_POINTER <= `ASRS_WBP_RST;
      end else begin
         WB_POINTER <= wbp_q;
      end
   end

   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         REG_RDATA <= 16'h0000;
      end else if (REG_RD) begin
         case (REG_ADDR)
            `ASRS_OFF_CTRL: REG_RDATA <= {14'h0000, ctrl_q};
            `ASRS_OFF_WBP: REG_RDATA <= wbp_q;
            `ASRS_OFF_LAST: REG_RDATA <= last_q;
            `ASRS_OFF_SHLO: REG_RDATA <= SH_RESULT[31:16];
            default: REG_RDATA <= 16'h0000;
         endcase
      end else begin
         REG_RDATA <= 16'h0000;
      end
   end

   // Amounts beyond sixteen either way are clamped to sixteen.
   always_comb begin
      sh_amt = SHIFT_CMD.amount;
      if (sh_amt > `ASRS_SH_MAX) begin
         sh_amt = `ASRS_SH_MAX;
      end else if (sh_amt < -`ASRS_SH_MAX) begin
         sh_amt = -`ASRS_SH_MAX;
      end
      sh_mag = sh_amt[5] ? 5'(-sh_amt) : sh_amt[4:0]; // RL18
   end

   always_comb begin
      case (SHIFT_CMD.src)
         ASRS_SRC_ACC_A: sh_operand = ACC_A; // RL17 RL21
         ASRS_SRC_ACC_B: sh_operand = ACC_B;
         ASRS_SRC_XBUS: begin
            if (sh_amt[5]) begin
               sh_operand = {24'h000000, XBUS_RDATA}; // RL20
            end else begin
               sh_operand = {{8{XBUS_RDATA[15] & SHIFT_CMD.arith}},
                             XBUS_RDATA, 16'h0000}; // RL20
            end
         end
         default: sh_operand = 40'h0000000000;
      endcase
   end

   always_comb begin
      if (sh_amt[5]) begin
         sh_next = sh_operand << sh_mag; // RL18
      end else if (SHIFT_CMD.arith) begin
         sh_next = 40'($signed(sh_operand) >>> sh_mag); // RL16
      end else begin
         sh_next = sh_operand >> sh_mag; // RL19
      end
   end

   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         SH_VALID <= 1'b0;
         SH_RESULT <= 40'h0000000000;
      end else begin
         SH_VALID <= SHIFT_REQ; // RL16
         if (SHIFT_REQ) begin
            SH_RESULT <= sh_next;
         end
      end
   end

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (SYS_RST);

   logic [39:0] chk_acc;
   assign chk_acc = STORE_CMD.target_b ? ACC_A : ACC_B;

   wb_target_a: assert property ( // RL1
      is_wb && STORE_CMD.wb_mode == ASRS_WB_INDIRECT &&
      !data_write_saturate_enable && !round_mode_select
      |=> XW_DATA == $past(chk_acc[31:16]) + 16'($past(chk_acc[15])))
      else $error("Write-back word not from non-target accumulator.");

   bus_write_a: assert property ( // RL2
      XW_EN |-> $past(is_store) ||
      ($past(is_wb) && $past(STORE_CMD.wb_mode) == ASRS_WB_INDIRECT))
      else $error("X bus write without a store.");

   direct_ptr_a: assert property ( // RL3
      is_wb && STORE_CMD.wb_mode == ASRS_WB_DIRECT
      |=> !XW_EN ##1 WB_POINTER == $past(store_word, 2))
      else $error("Direct write-back did not load pointer.");

   post_inc_a: assert property ( // RL4
      is_wb && STORE_CMD.wb_mode == ASRS_WB_INDIRECT
      |=> XW_ADDR == $past(wbp_q) && wbp_q == $past(wbp_q) + 16'h0002)
      else $error("Indirect write-back address or step wrong.");

   trunc_store_a: assert property ( // RL6
      is_store && STORE_CMD.op == ASRS_OP_STORE_TRUNC &&
      !data_write_saturate_enable
      |=> XW_DATA == $past(src_acc[31:16]))
      else $error("Truncated store changed the high word.");

   conv_half_a: assert property ( // RL8
      STORE_REQ && do_round && round_mode_select &&
      src_acc[15:0] == 16'h8000 |-> rounded[0] == 1'b0)
      else $error("Convergent round of half not to even.");

   sat_pos_a: assert property ( // RL12
      (is_store || is_wb) && data_write_saturate_enable &&
      !src_acc[39] && rounded[23:15] != 9'h000
      |=> last_q == 16'h7FFF)
      else $error("Positive saturation value wrong.");

   sat_neg_a: assert property ( // RL13
      (is_store || is_wb) && data_write_saturate_enable &&
      src_acc[39] && rounded[23] && rounded[23:15] != 9'h1FF
      |=> last_q == 16'h8000)
      else $error("Negative saturation value wrong.");

   sat_off_a: assert property ( // RL15
      is_store && !data_write_saturate_enable |=> XW_DATA == $past(rounded[15:0]))
      else $error("Unsaturated store altered the value.");

   shift_once_a: assert property ( // RL18
      SHIFT_REQ && SHIFT_CMD.amount == 6'sd0 && SHIFT_CMD.src != ASRS_SRC_XBUS
      |=> SH_VALID && SH_RESULT == $past(sh_operand))
      else $error("Zero shift modified the operand.");

   no_wb_a: assert property ( // RL1
      STORE_REQ && STORE_CMD.op >= ASRS_OP_MULTIPLY_ONLY |=> !XW_EN)
      else $error("Multiply-only form wrote memory.");

   conv_round_a: assert property ( // RL7
      is_store && STORE_CMD.op == ASRS_OP_STORE_RND && !round_mode_select &&
      !data_write_saturate_enable
      |=> XW_DATA == $past(src_acc[31:16]) + 16'($past(src_acc[15])))
      else $error("Conventional round of the high word wrong.");

   wb_rounds_a: assert property ( // RL10
      is_wb && STORE_CMD.wb_mode == ASRS_WB_INDIRECT && !data_write_saturate_enable &&
      !round_mode_select && src_acc[15]
      |=> XW_DATA != $past(src_acc[31:16]))
      else $error("Write-back word was not rounded.");

   store_target_a: assert property ( // RL9
      is_store && STORE_CMD.op == ASRS_OP_STORE_TRUNC && !data_write_saturate_enable
      |=> XW_DATA == $past(STORE_CMD.target_b ? ACC_B[31:16] : ACC_A[31:16]) &&
      XW_ADDR == $past(STORE_CMD.addr))
      else $error("Store did not write the target accumulator.");

   ovf_clamp_a: assert property ( // RL14
      (is_store || is_wb) && data_write_saturate_enable && src_ovf
      |=> last_q == ($past(src_acc[39]) ? 16'h8000 : 16'h7FFF))
      else $error("Overflowed source was not clamped by its sign.");

   src_b_a: assert property ( // RL17
      SHIFT_REQ && SHIFT_CMD.src == ASRS_SRC_ACC_B && SHIFT_CMD.amount == -6'sd4
      |=> SH_RESULT == {$past(ACC_B[35:0]), 4'h0})
      else $error("Shift of accumulator B wrong.");

   xbus_left_a: assert property ( // RL20
      SHIFT_REQ && SHIFT_CMD.src == ASRS_SRC_XBUS && SHIFT_CMD.amount < 6'sd0
      |=> SH_RESULT[39:32] == 8'h00)
      else $error("X bus operand not placed low for a left shift.");

   shift_clamp_a: assert property ( // RL16
      SHIFT_REQ && SHIFT_CMD.amount > 6'sd16 && !SHIFT_CMD.arith &&
      SHIFT_CMD.src == ASRS_SRC_ACC_A
      |=> SH_RESULT == {16'h0000, $past(ACC_A[39:16])})
      else $error("Oversized shift not limited to sixteen.");

   arith_sign_a: assert property ( // RL19
      SHIFT_REQ && SHIFT_CMD.arith && SHIFT_CMD.src == ASRS_SRC_ACC_A &&
      SHIFT_CMD.amount > 6'sd0
      |=> SH_RESULT[39] == $past(ACC_A[39]))
      else $error("Arithmetic shift lost the sign of bit 39.");

   shift_pulse_a: assert property ( // RL16
      SH_VALID == $past(SHIFT_REQ))
      else $error("Shift valid not one cycle after request.");

   wb_ptr_copy_a: assert property ( // RL3
      WB_POINTER == $past(wbp_q))
      else $error("Pointer output not one cycle behind the register.");

   cov_wb_ind: cover property (is_wb && STORE_CMD.wb_mode == ASRS_WB_INDIRECT);
   cov_wb_dir: cover property (is_wb && STORE_CMD.wb_mode == ASRS_WB_DIRECT);
   cov_sat: cover property (is_store && data_write_saturate_enable ##1 XW_EN);
   cov_shl: cover property (SHIFT_REQ && SHIFT_CMD.amount < 6'sd0);
   cov_shr_x: cover property (SHIFT_REQ && SHIFT_CMD.src == ASRS_SRC_XBUS);
endmodule

/* File: verif/asrs_mem_model.sv */
`timescale 1ns/1ns
// Data space memory on the X write bus; it records every word written.
module asrs_mem_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [15:0] wr_addr,
   input wire logic [15:0] wr_data,
   output logic [15:0] last_addr,
   output logic [15:0] last_data,
   output logic [7:0] wr_cnt,
   input wire logic [15:0] peek_addr,
   output logic [15:0] peek_data
);
   logic [15:0] mem [0:127];
   // Words land by word index; the peek port reads one back for checks.
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr[7:1]] <= wr_data;
      end
   end
   assign peek_data = mem[peek_addr[7:1]];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         last_addr <= 16'h0000;
         last_data <= 16'h0000;
         wr_cnt <= 8'h00;
      end else if (wr_en) begin
         last_addr <= wr_addr;
         last_data <= wr_data;
         wr_cnt <= wr_cnt + 8'h01;
      end
   end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
   $display("FAIL %0t got %h expected %h", $time, (a), (b)); end end
module testbench;
   import asrs_pkg::*;
   typedef struct {logic [39:0] acc; logic ovf; logic [15:0] ctrl; asrs_op_t op;
      logic [15:0] exp;} asrs_row_t;
   typedef struct {asrs_src_t src; logic signed [5:0] amt; logic ar; logic [39:0] a;
      logic [39:0] b; logic [15:0] x; logic [39:0] exp;} asrs_sh_t;
   logic mclk, sys_rst, reg_wr, reg_rd, ovf_a, ovf_b, st_req, sh_req, xw_en, sh_valid;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, xbus, xw_addr, xw_data, wbp, m_addr, m_data, rv, m_peek;
   logic [39:0] acc_a, acc_b, sh_res;
   logic [7:0] m_cnt, cnt0;
   asrs_store_req_t st_cmd;
   asrs_shift_req_t sh_cmd;
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   asrs_row_t rows [12] = '{
      '{40'h00_1234_7FFF, 0, 16'h0000, ASRS_OP_STORE_RND, 16'h1234},
      '{40'h00_1234_8000, 0, 16'h0000, ASRS_OP_STORE_RND, 16'h1235},
      '{40'h00_1234_8000, 0, 16'h0001, ASRS_OP_STORE_RND, 16'h1234},
      '{40'h00_1235_8000, 0, 16'h0001, ASRS_OP_STORE_RND, 16'h1236},
      '{40'h00_1234_8001, 0, 16'h0001, ASRS_OP_STORE_RND, 16'h1235},
      '{40'h00_1234_FFFF, 0, 16'h0000, ASRS_OP_STORE_TRUNC, 16'h1234},
      '{40'h00_9000_0000, 0, 16'h0002, ASRS_OP_STORE_TRUNC, 16'h7FFF},
      '{40'hFF_7000_0000, 0, 16'h0002, ASRS_OP_STORE_TRUNC, 16'h8000},
      '{40'h00_9000_0000, 0, 16'h0000, ASRS_OP_STORE_TRUNC, 16'h9000},
      '{40'h00_7FFF_8000, 0, 16'h0003, ASRS_OP_STORE_RND, 16'h7FFF},
      '{40'hFF_8000_0000, 0, 16'h0002, ASRS_OP_STORE_TRUNC, 16'h8000},
      '{40'h00_1234_0000, 1, 16'h0002, ASRS_OP_STORE_TRUNC, 16'h7FFF}};
   asrs_sh_t shs [9] = '{
      '{ASRS_SRC_ACC_A, 3, 1, 40'h80_0000_0010, 0, 0, 40'hF0_0000_0002},
      '{ASRS_SRC_ACC_A, 3, 0, 40'h80_0000_0010, 0, 0, 40'h10_0000_0002},
      '{ASRS_SRC_ACC_B, -4, 0, 0, 40'h00_0000_1234, 0, 40'h00_0001_2340},
      '{ASRS_SRC_ACC_A, 0, 1, 40'h12_3456_789A, 0, 0, 40'h12_3456_789A},
      '{ASRS_SRC_ACC_A, 16, 0, 40'h12_3456_789A, 0, 0, 40'h00_0012_3456},
      '{ASRS_SRC_ACC_A, -16, 0, 40'h00_0000_ABCD, 0, 0, 40'h00_ABCD_0000},
      '{ASRS_SRC_XBUS, 1, 1, 0, 0, 16'h8001, 40'hFF_C000_8000},
      '{ASRS_SRC_XBUS, -2, 0, 0, 0, 16'h4001, 40'h00_0001_0004},
      '{ASRS_SRC_ACC_A, 20, 0, 40'h12_3456_789A, 0, 0, 40'h00_0012_3456}};
   asrs_store asrs_store_i (.MCLK(mclk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .ACC_A(acc_a), .ACC_B(acc_b), .ACC_A_OVF(ovf_a), .ACC_B_OVF(ovf_b),
      .STORE_REQ(st_req), .STORE_CMD(st_cmd), .SHIFT_REQ(sh_req), .SHIFT_CMD(sh_cmd),
      .XBUS_RDATA(xbus), .XW_EN(xw_en), .XW_ADDR(xw_addr), .XW_DATA(xw_data),
      .WB_POINTER(wbp), .SH_VALID(sh_valid), .SH_RESULT(sh_res));
   asrs_mem_model asrs_mem_model_i (.clk(mclk), .rst(sys_rst), .wr_en(xw_en),
      .wr_addr(xw_addr), .wr_data(xw_data), .last_addr(m_addr), .last_data(m_data),
      .wr_cnt(m_cnt), .peek_addr(16'h0100), .peek_data(m_peek));
   initial begin
      mclk = 0;
      forever #25 mclk = ~mclk;
   end
   task automatic give_verdict();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         give_verdict();
      end
   end
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1;
      @(posedge mclk);
      reg_wr <= 0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge mclk);
      reg_rd <= 0;
      #1 d = reg_rdata;
   endtask
   task automatic store(input asrs_op_t op, input asrs_wb_mode_t m, input logic tb,
      input logic [15:0] ad);
      @(posedge mclk);
      st_req <= 1;
      st_cmd <= '{op, m, tb, ad};
      @(posedge mclk);
      st_req <= 0;
      #1;
   endtask
   initial begin
      {reg_wr, reg_rd, ovf_a, ovf_b, st_req, sh_req} = 6'h00;
      {reg_addr, reg_wdata, xbus, acc_a, acc_b} = '0;
      st_cmd = '0;
      sh_cmd = '0;
      sys_rst = 1;
      repeat (2) @(posedge mclk);
      sys_rst <= 0;
      foreach (rows[i]) begin
         wr_reg(4'h0, rows[i].ctrl);
         acc_a <= rows[i].acc;
         acc_b <= ~rows[i].acc;
         ovf_a <= rows[i].ovf;
         store(rows[i].op, ASRS_WB_DIRECT, 0, 16'h0040);
         `CHK({xw_en, xw_data}, {1'b1, rows[i].exp})
         #50 `CHK({m_addr, m_data}, {16'h0040, rows[i].exp})
      end
      rd_reg(4'h2, rv);
      `CHK(rv, 16'h7FFF)
      foreach (shs[i]) begin
         @(posedge mclk);
         ovf_a <= 0;
         {acc_a, acc_b, xbus} <= {shs[i].a, shs[i].b, shs[i].x};
         sh_req <= 1;
         sh_cmd <= '{shs[i].src, shs[i].amt, shs[i].ar};
         @(posedge mclk);
         sh_req <= 0;
         #1 `CHK({sh_valid, sh_res}, {1'b1, shs[i].exp})
      end
      rd_reg(4'h3, rv);
      `CHK(rv, 16'h0012)
      rd_reg(4'h5, rv);
      `CHK(rv, 16'h0000)
      wr_reg(4'h0, 16'h0000);
      wr_reg(4'h1, 16'h0100);
      acc_b <= 40'h00_1234_8000;
      store(ASRS_OP_MAC_WB, ASRS_WB_INDIRECT, 0, 16'h0000);
      `CHK({xw_en, xw_addr, xw_data}, {1'b1, 16'h0100, 16'h1235})
      store(ASRS_OP_MAC_WB, ASRS_WB_INDIRECT, 0, 16'h0000);
      `CHK({xw_en, xw_addr}, {1'b1, 16'h0102})
      `CHK(m_peek, 16'h1235)
      rd_reg(4'h1, rv);
      `CHK(rv, 16'h0104)
      cnt0 = m_cnt;
      @(posedge mclk);
      acc_a <= 40'h00_4321_8000;
      store(ASRS_OP_MAC_WB, ASRS_WB_DIRECT, 1, 16'h0000);
      `CHK(xw_en, 1'b0)
      rd_reg(4'h1, rv);
      `CHK(rv, 16'h4322)
      `CHK(wbp, 16'h4322)
      for (int k = 4; k < 9; k++) begin
         store(asrs_op_t'(k[2:0]), ASRS_WB_INDIRECT, 0, 16'h0000);
         `CHK(xw_en, 1'b0)
      end
      #50 `CHK(m_cnt, cnt0)
      @(posedge mclk);
      sys_rst <= 1;
      @(posedge mclk);
      sys_rst <= 0;
      #1 `CHK({xw_en, xw_addr, xw_data, wbp, sh_valid, sh_res, reg_rdata}, 106'h0)
      rd_reg(4'h1, rv);
      `CHK(rv, 16'h0000)
      rd_reg(4'h0, rv);
      `CHK(rv, 16'h0000)
      give_verdict();
   end
endmodule
